// file: hdl/dacro_defs.svh
// register offsets, field positions, reset values and timing figures of the readout block
`ifndef DACRO_DEFS_SVH
`define DACRO_DEFS_SVH

`define OFF_SENSOR_HIGH 8'h00
`define OFF_SENSOR_LOW 8'h01
`define OFF_CHAN0_HIGH 8'h02
`define OFF_CHAN0_LOW 8'h03
`define OFF_CHAN1_HIGH 8'h04
`define OFF_CHAN1_LOW 8'h05
`define OFF_STATUS 8'h07
`define OFF_OVR_CTL 8'h08
`define OFF_FORCED_BASE 8'h09
`define OFF_ACCESS 8'h11

`define OVR_TEMP_BIT 0
`define OVR_DAC_BIT 1

`define KEY_FIRST 8'hCD
`define KEY_LEVEL1 8'hEF
`define KEY_LEVEL2 8'hF0

`define STATUS_RESET 8'h01
`define OVR_CTL_RESET 2'h0
`define WORD_RESET 12'h000

`define CLK_HZ 20000000
`define REFRESH_MS 25
`define SETTLE_MS 100

`endif

// file: hdl/dacro_pkg.sv
// types shared by the readout and override block
package dacro_pkg;
  typedef logic [11:0] word12_type;
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_type;
endpackage

// file: hdl/forced_word_stage.sv
// one split override word: upper nibble waits until the lower byte is written
`timescale 1ns/10ps
`include "dacro_defs.svh"
module forced_word_stage (
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic hi_we,
  input wire logic lo_we,
  input wire logic [7:0] wdata,
  output dacro_pkg::word12_type word
);
  import dacro_pkg::*;

  logic [3:0] pending;
  logic [3:0] next_pending;
  word12_type next_word;

  // hold the nibble, commit the whole word on the low byte
  always_comb
  begin
    next_pending = hi_we ? wdata[3:0] : pending;
    next_word = lo_we ? {pending, wdata} : word;
  end

  // state registers, cleared at power up
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pending <= 4'h0;
      word <= `WORD_RESET;
    end
    else
    begin
      pending <= next_pending;
      word <= next_word;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  a_pending_holds: assert property (hi_we && !lo_we |=> $stable(word))
    else $error("upper nibble write changed the applied word");
  a_low_commit: assert property (hi_we ##1 !hi_we ##1 (lo_we && !hi_we) |=>
    word == {$past(wdata[3:0], 3), $past(wdata)})
    else $error("low byte write did not apply the pending nibble");
endmodule // forced_word_stage

// file: hdl/temp_dac_readout_override.sv
// readout, coherent snapshot and override path of the temperature-compensated dual DAC
`timescale 1ns/10ps
`include "dacro_defs.svh"

module temp_dac_readout_override #(
  parameter int REFRESH_CYCLES = `REFRESH_MS * (`CLK_HZ / 1000),
  parameter int SETTLE_CYCLES = `SETTLE_MS * (`CLK_HZ / 1000)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire dacro_pkg::word12_type measured_temp,
  output dacro_pkg::word12_type table_index,
  input wire dacro_pkg::word12_type table_word0,
  input wire dacro_pkg::word12_type table_word1,
  output dacro_pkg::word12_type chan0_dac_in,
  output dacro_pkg::word12_type chan1_dac_in
);
  import dacro_pkg::*;

  localparam logic [31:0] REFRESH_LAST = 32'(REFRESH_CYCLES - 1);
  localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYCLES - 1);

  logic [1:0] rst_pipe;
  logic rst_sync;
  logic [31:0] refresh_cnt, next_refresh_cnt;
  logic refresh_tick, commit_due;
  word12_type sample_hold, next_sample_hold;
  word12_type temp_word, next_temp_word;
  word12_type result0, next_result0, result1, next_result1;
  word12_type next_table_index, next_chan0_dac_in, next_chan1_dac_in;
  logic [31:0] settle_cnt, next_settle_cnt;
  logic [7:0] sensor_valid_status, next_sensor_valid_status;
  logic snap_valid, next_snap_valid;
  logic [7:0] snap_temp_low, next_snap_temp_low;
  word12_type snap_chan0, next_snap_chan0, snap_chan1, next_snap_chan1;
  logic [1:0] path_override_control, next_path_override_control;
  key_state_type key_state, next_key_state;
  logic level1, next_level1, level2, next_level2;
  logic [7:0] next_reg_rdata;
  logic [2:0] hi_we, lo_we;
  word12_type forced [3];
  word12_type chan0_src, chan1_src;
  logic rd_high, wr_access, wr_ovr_ctl;

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_sync = rst_pipe[1];

  // access decode; only level two may touch override state
  assign rd_high = reg_rd && reg_addr == `OFF_SENSOR_HIGH;
  assign wr_access = reg_wr && reg_addr == `OFF_ACCESS;
  assign wr_ovr_ctl = reg_wr && level2 && reg_addr == `OFF_OVR_CTL;

  // forced temperature, channel 0 and channel 1 words
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_forced
      assign hi_we[i] = reg_wr && level2 && reg_addr == 8'(`OFF_FORCED_BASE + 2 * i);
      assign lo_we[i] = reg_wr && level2 && reg_addr == 8'(`OFF_FORCED_BASE + 2 * i + 1);
      forced_word_stage u_stage (
        .mclk(mclk),
        .rst_sync_n(rst_sync),
        .hi_we(hi_we[i]),
        .lo_we(lo_we[i]),
        .wdata(reg_wdata),
        .word(forced[i])
      );
    end
  endgenerate

  // refresh timer, sample capture and coherent result commit
  assign refresh_tick = refresh_cnt == REFRESH_LAST;
  always_comb
  begin
    next_refresh_cnt = refresh_tick ? 32'h0 : refresh_cnt + 32'h1;
    next_sample_hold = refresh_tick ? measured_temp : sample_hold;
    next_temp_word = commit_due ? sample_hold : temp_word;
    next_result0 = commit_due ? table_word0 : result0;
    next_result1 = commit_due ? table_word1 : result1;
    // raw twos complement temperature indexes the table
    if (path_override_control[`OVR_TEMP_BIT])
      next_table_index = forced[0];
    else
      next_table_index = next_sample_hold;
    // offset binary words pass to the converters untouched
    next_chan0_dac_in = path_override_control[`OVR_DAC_BIT] ? forced[1] : result0;
    next_chan1_dac_in = path_override_control[`OVR_DAC_BIT] ? forced[2] : result1;
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      refresh_cnt <= 32'h0;
      commit_due <= 1'b0;
      sample_hold <= `WORD_RESET;
      temp_word <= `WORD_RESET;
      result0 <= `WORD_RESET;
      result1 <= `WORD_RESET;
      table_index <= `WORD_RESET;
      chan0_dac_in <= `WORD_RESET;
      chan1_dac_in <= `WORD_RESET;
    end
    else
    begin
      refresh_cnt <= next_refresh_cnt;
      commit_due <= refresh_tick;
      sample_hold <= next_sample_hold;
      temp_word <= next_temp_word;
      result0 <= next_result0;
      result1 <= next_result1;
      table_index <= next_table_index;
      chan0_dac_in <= next_chan0_dac_in;
      chan1_dac_in <= next_chan1_dac_in;
    end
  end

  // power-up settle counter; status clears once the sensor is valid
  always_comb
  begin
    next_settle_cnt = (settle_cnt == SETTLE_LAST) ? settle_cnt : settle_cnt + 32'h1;
    next_sensor_valid_status = (settle_cnt == SETTLE_LAST) ? 8'h00 : sensor_valid_status;
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      settle_cnt <= 32'h0;
      sensor_valid_status <= `STATUS_RESET;
    end
    else
    begin
      settle_cnt <= next_settle_cnt;
      sensor_valid_status <= next_sensor_valid_status;
    end
  end

  // shadow snapshot taken when the upper temperature nibble is read
  always_comb
  begin
    next_snap_valid = snap_valid;
    next_snap_temp_low = snap_temp_low;
    next_snap_chan0 = snap_chan0;
    next_snap_chan1 = snap_chan1;
    if (rd_high)
    begin
      next_snap_valid = 1'b1;
      next_snap_temp_low = temp_word[7:0];
      next_snap_chan0 = result0;
      next_snap_chan1 = result1;
    end
    else if (reg_rd && reg_addr == `OFF_CHAN1_LOW)
      next_snap_valid = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      snap_valid <= 1'b0;
      snap_temp_low <= 8'h00;
      snap_chan0 <= `WORD_RESET;
      snap_chan1 <= `WORD_RESET;
    end
    else
    begin
      snap_valid <= next_snap_valid;
      snap_temp_low <= next_snap_temp_low;
      snap_chan0 <= next_snap_chan0;
      snap_chan1 <= next_snap_chan1;
    end
  end

  // override control and the two-byte access unlock
  always_comb
  begin
    next_path_override_control = wr_ovr_ctl ? reg_wdata[1:0] : path_override_control;
    next_key_state = key_state;
    next_level1 = level1;
    next_level2 = level2;
    if (wr_access)
    begin
      case (key_state)
        KEY_IDLE:
          next_key_state = (reg_wdata == `KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
        KEY_ARMED:
        begin
          if (reg_wdata == `KEY_LEVEL2)
          begin
            next_level2 = 1'b1;
            next_level1 = 1'b1;
          end
          else if (reg_wdata == `KEY_LEVEL1)
            next_level1 = 1'b1;
          next_key_state = (reg_wdata == `KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
        end
        default:
          next_key_state = KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      path_override_control <= `OVR_CTL_RESET;
      key_state <= KEY_IDLE;
      level1 <= 1'b0;
      level2 <= 1'b0;
    end
    else
    begin
      path_override_control <= next_path_override_control;
      key_state <= next_key_state;
      level1 <= next_level1;
      level2 <= next_level2;
    end
  end

  // read mux; read-only offsets have no write path
  assign chan0_src = snap_valid ? snap_chan0 : result0;
  assign chan1_src = snap_valid ? snap_chan1 : result1;
  always_comb
  begin
    next_reg_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        `OFF_SENSOR_HIGH: next_reg_rdata = {4'h0, temp_word[11:8]};
        `OFF_SENSOR_LOW: next_reg_rdata = snap_valid ? snap_temp_low : temp_word[7:0];
        `OFF_CHAN0_HIGH: next_reg_rdata = {4'h0, chan0_src[11:8]};
        `OFF_CHAN0_LOW: next_reg_rdata = chan0_src[7:0];
        `OFF_CHAN1_HIGH: next_reg_rdata = {4'h0, chan1_src[11:8]};
        `OFF_CHAN1_LOW: next_reg_rdata = chan1_src[7:0];
        `OFF_STATUS: next_reg_rdata = sensor_valid_status;
        `OFF_OVR_CTL: next_reg_rdata = {6'h00, path_override_control};
        `OFF_ACCESS: next_reg_rdata = {6'h00, level2, level1};
        default:
        begin
          next_reg_rdata = 8'h00;
          for (int i = 0; i < 3; i++)
          begin
            if (reg_addr == 8'(`OFF_FORCED_BASE + 2 * i))
              next_reg_rdata = {4'h0, forced[i][11:8]};
            if (reg_addr == 8'(`OFF_FORCED_BASE + 2 * i + 1))
              next_reg_rdata = forced[i][7:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync)
  begin
    if (!rst_sync)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_reg_rdata;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync);

  a_reset_clears_ovr: assert property (disable iff (1'b0)
    !rst_sync |-> path_override_control == 2'h0 && forced[1] == 12'h000)
    else $error("override state not cleared during reset");
  a_temp_high_layout: assert property (rd_high |=>
    reg_rdata == {4'h0, $past(temp_word[11:8])})
    else $error("upper temperature register has wrong layout");
  a_refresh_sample: assert property (refresh_tick |=> ##1
    temp_word == $past(measured_temp, 2))
    else $error("refresh did not load the measured sample");
  a_low_coherent: assert property (rd_high ##1 !reg_rd ##1
    (reg_rd && reg_addr == `OFF_SENSOR_LOW) |=> reg_rdata == $past(temp_word[7:0], 3))
    else $error("lower temperature byte not from the snapshot sample");
  a_dac_coherent: assert property (rd_high ##1 !reg_rd ##1
    (reg_rd && reg_addr == `OFF_CHAN1_LOW) |=> reg_rdata == $past(result1[7:0], 3))
    else $error("channel 1 low byte not from the snapshot");
  a_dac_high_zero: assert property (reg_rd && (reg_addr == `OFF_CHAN0_HIGH ||
    reg_addr == `OFF_CHAN1_HIGH) |=> reg_rdata[7:4] == 4'h0)
    else $error("upper DAC register reserved bits not zero");
  a_dac_from_table: assert property (!path_override_control[`OVR_DAC_BIT]
    |=> chan0_dac_in == $past(result0))
    else $error("channel 0 not fed by computed word");
  a_dac_forced: assert property (path_override_control[`OVR_DAC_BIT]
    |=> chan1_dac_in == $past(forced[2]) && chan0_dac_in == $past(forced[1]))
    else $error("DAC override did not drive forced words");
  a_index_forced: assert property (path_override_control[`OVR_TEMP_BIT]
    |=> table_index == $past(forced[0]))
    else $error("temperature override did not index the table");
  a_status_settle: assert property ($past(settle_cnt == SETTLE_LAST)
    |-> sensor_valid_status == 8'h00)
    else $error("sensor status not cleared after settle time");
  a_locked_write: assert property (reg_wr && !level2 && reg_addr == `OFF_OVR_CTL
    |=> $stable(path_override_control))
    else $error("override control written without level two");
  a_ro_write: assert property (reg_wr && !reg_rd && reg_addr <= `OFF_STATUS
    |=> $stable(snap_chan0) && $stable(path_override_control))
    else $error("write to read-only offset changed state");

  c_ordered_read: cover property (rd_high ##1 reg_rd [*5]);
  c_unlock: cover property (wr_access ##1 wr_access ##1 level2);
  c_dac_override: cover property (path_override_control == 2'h2);
  c_temp_override: cover property (path_override_control == 2'h1 ##1 commit_due);
endmodule // temp_dac_readout_override

// file: testbench/table_model.sv
// compensation table stand-in: two computed DAC words from the table index
`timescale 1ns/10ps
module table_model (
  input wire dacro_pkg::word12_type table_index,
  output dacro_pkg::word12_type table_word0,
  output dacro_pkg::word12_type table_word1
);
  import dacro_pkg::*;
  // distinct mapping per channel so a swapped channel shows up
  assign table_word0 = {table_index[3:0], table_index[11:4]};
  assign table_word1 = ~table_index;
endmodule // table_model

// file: testbench/test_temp_dac_readout_override.sv
// self-checking bench of the readout and override block
`timescale 1ns/10ps
`include "dacro_defs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("FAIL %0t: got %h expected %h", $time, got, exp); end end
module test_temp_dac_readout_override;
  import dacro_pkg::*;
  localparam int REF = 20;
  localparam int SET = 50;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  word12_type measured_temp = 12'h000;
  word12_type table_index, table_word0, table_word1, chan0_dac_in, chan1_dac_in;
  int failures = 0;
  int n_compared = 0;
  word12_type t1, t2, f0, f1, w0, w1;

  // 20 MHz clock
  always #25 mclk = ~mclk;

  temp_dac_readout_override #(.REFRESH_CYCLES(REF), .SETTLE_CYCLES(SET)) uut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .measured_temp(measured_temp), .table_index(table_index),
    .table_word0(table_word0), .table_word1(table_word1),
    .chan0_dac_in(chan0_dac_in), .chan1_dac_in(chan1_dac_in)
  );

  table_model partner (
    .table_index(table_index), .table_word0(table_word0), .table_word1(table_word1)
  );

  // expected table words, written independently of the partner
  function automatic word12_type e0(input word12_type x);
    return (x << 8) | (x >> 4);
  endfunction
  function automatic word12_type e1(input word12_type x);
    return x ^ 12'hFFF;
  endfunction

  // verdict and end of run
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one write strobe on the byte port, then a released cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // one read strobe; data taken just after the edge that sampled it
  task automatic rd(input logic [7:0] a, input logic [7:0] m, output logic [7:0] q);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata & m;
  endtask

  // read, mask and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    logic [7:0] q;
    rd(a, m, q);
    `CHK(q, e)
  endtask

  // bounded poll until the sensor reports valid
  task automatic wait_settle();
    logic [7:0] q;
    for (int i = 0; i < SET + 20; i++)
    begin
      rd(`OFF_STATUS, 8'hFF, q);
      if (q === 8'h00)
        return;
    end
    failures++;
    report_and_stop();
  endtask

  // hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h6b0a506a));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rc(`OFF_STATUS, 8'h01);
    rc(`OFF_OVR_CTL, 8'h00);
    rc(8'h0C, 8'h00);
    wait_settle();
    rc(`OFF_STATUS, 8'h00);
    // sampled words, snapshot across a refresh, corner temperatures first
    for (int k = 0; k < 6; k++)
    begin
      t1 = 12'($urandom);
      if (k == 0)
        t1 = 12'h800;
      if (k == 1)
        t1 = 12'h7FF;
      w0 = e0(t1);
      w1 = e1(t1);
      measured_temp <= t1;
      repeat (2 * REF + 5) @(posedge mclk);
      wr(`OFF_SENSOR_LOW, 8'h5A);
      wr(`OFF_CHAN0_HIGH, 8'hA5);
      rc(`OFF_SENSOR_HIGH, {4'h0, t1[11:8]}, 8'h6F);
      t2 = ~t1;
      measured_temp <= t2;
      repeat (2 * REF + 5) @(posedge mclk);
      if (k % 2 == 0)
        rc(`OFF_SENSOR_LOW, t1[7:0]);
      rc(`OFF_CHAN0_HIGH, {4'h0, w0[11:8]});
      rc(`OFF_CHAN0_LOW, w0[7:0]);
      rc(`OFF_CHAN1_HIGH, {4'h0, w1[11:8]});
      rc(`OFF_CHAN1_LOW, w1[7:0]);
      rc(`OFF_SENSOR_LOW, t2[7:0]);
      `CHK(chan0_dac_in, e0(t2))
      `CHK(chan1_dac_in, e1(t2))
    end
    // high read directly followed by the low byte, then by the last DAC byte
    w1 = e1(t2);
    rc(`OFF_SENSOR_HIGH, {4'h0, t2[11:8]}, 8'h6F);
    rc(`OFF_SENSOR_LOW, t2[7:0]);
    rc(`OFF_SENSOR_HIGH, {4'h0, t2[11:8]}, 8'h6F);
    rc(`OFF_CHAN1_LOW, w1[7:0]);
    // override writes refused while locked
    wr(`OFF_OVR_CTL, 8'h01);
    rc(`OFF_OVR_CTL, 8'h00);
    wr(`OFF_ACCESS, `KEY_FIRST);
    wr(`OFF_ACCESS, `KEY_LEVEL2);
    rc(`OFF_ACCESS, 8'h03);
    f0 = 12'($urandom);
    f1 = 12'($urandom);
    // forced temperature: upper nibble waits for the lower byte
    wr(8'h09, {4'h0, f0[11:8]});
    rc(8'h09, 8'h00);
    wr(8'h0A, f0[7:0]);
    rc(8'h09, {4'h0, f0[11:8]});
    wr(`OFF_OVR_CTL, 8'h01);
    rc(`OFF_OVR_CTL, 8'h01);
    repeat (2 * REF + 5) @(posedge mclk);
    #1;
    `CHK(table_index, f0)
    `CHK(chan1_dac_in, e1(f0))
    // forced DAC words drive both channels from one bit
    wr(8'h0B, {4'h0, f1[11:8]});
    wr(8'h0C, f1[7:0]);
    wr(8'h0D, {4'h0, f0[11:8]});
    wr(8'h0E, f0[7:0]);
    wr(`OFF_OVR_CTL, 8'h02);
    repeat (4) @(posedge mclk);
    #1;
    `CHK(chan0_dac_in, f1)
    `CHK(chan1_dac_in, f0)
    wr(`OFF_OVR_CTL, 8'h00);
    repeat (2 * REF + 5) @(posedge mclk);
    #1;
    `CHK(table_index, t2)
    `CHK(chan0_dac_in, e0(t2))
    rc(8'h20, 8'h00);
    // second reset in mid-run clears the volatile override state
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rc(`OFF_OVR_CTL, 8'h00);
    rc(8'h0E, 8'h00);
    rc(`OFF_STATUS, 8'h01);
    report_and_stop();
  end
endmodule // test_temp_dac_readout_override
